// file: sbc_line_controller.sv
`timescale 1ns/1ns

// ************************************************************
// Word buffer between the host and the transmitter.
// ************************************************************
module sbc_fifo #(
   parameter int W     = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input  wire logic         core_clk_i,
   input  wire logic         sys_rst_i,
   // Filling side.
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   // Draining side.
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wptr;
      logic [AW-1:0]           rptr;
      logic [AW:0]             cnt;
      logic                    full;
      logic                    empty;
   } sbc_fifo_state_t;
   sbc_fifo_state_t s_ff;
   sbc_fifo_state_t nxt_s;
   logic            push;
   logic            pop;

   always_comb begin
      nxt_s = s_ff;
      push  = in_valid_i && !s_ff.full;
      pop   = out_ready_i && !s_ff.empty;
      nxt_s.mem[s_ff.wptr] = push ? in_data_i : s_ff.mem[s_ff.wptr];
      nxt_s.wptr           = push ? AW'(s_ff.wptr + 1'b1) : s_ff.wptr;
      nxt_s.rptr           = pop ? AW'(s_ff.rptr + 1'b1) : s_ff.rptr;
      nxt_s.cnt   = (AW + 1)'(s_ff.cnt + {AW'(0), push} - {AW'(0), pop});
      nxt_s.full  = (nxt_s.cnt == (AW + 1)'(DEPTH));
      nxt_s.empty = (nxt_s.cnt == '0);
   end
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s_ff       <= '0;
         s_ff.empty <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end
   assign in_ready_o  = !s_ff.full;
   assign out_valid_o = !s_ff.empty;
   assign out_data_o  = s_ff.mem[s_ff.rptr];
   fifo_count_a : assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      s_ff.cnt <= (AW + 1)'(DEPTH)) else $error("Buffer count above depth.");
endmodule // sbc_fifo

// ************************************************************
// Line controller: block check, sync response, test block.
// ************************************************************
// What this block does
// - An interrupt word from the remote end raises a sticky remote attention flag.
// - Every received block is checked here and a failure is flagged to the host.
// - The sender computes a check word and sends it right after the last data word.
// - The receiver compares the received check word with its own code.
// - The check word is a 12-bit cyclic code built serially over data bits.
// - The code catches any odd error count and every burst of 12 bits or less.
// - A local test sends sync, one fixed data word and its check word.
// - On detecting a sync word the receiver sends a response code back.
// - The response goes out while data reception carries on undisturbed.
// - The sender shows the host whether its sync word was acknowledged.
// - At the 12th bit after the check word a mismatch sets the cyclic error flag.
// - A cyclic error also sets the summary error flag.
// - The 3-bit response clears the sender's sync-not-acknowledged flag.
// - Words move serially at one 12-bit word per 300 microseconds.
module sbc_line_controller
   import sbc_pkg::*;
#(
   parameter int          BIT_CYCLES_P = BIT_CYCLES,
   parameter logic [11:0] CRC_POLY_P   = CRC_POLY,
   parameter logic [11:0] CRC_INIT_P   = CRC_INIT
) (
   // Clock and reset.
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   // Host transmit side.
   input  wire logic [11:0] tx_data_i,
   input  wire logic        tx_valid_i,
   output logic             tx_ready_o,
   input  wire logic        tx_start_i,
   input  wire logic        test_start_i,
   // Host receive side.
   input  wire logic        rx_enable_i,
   output logic [11:0]      rx_data_o,
   output logic             rx_valid_o,
   // Status and clears.
   output logic             tx_busy_o,
   output logic             sync_nak_o,
   output logic             cyc_err_o,
   output logic             err_sum_o,
   output logic             remote_intr_o,
   input  wire logic        err_clr_i,
   input  wire logic        intr_clr_i,
   // Serial line toward the data set.
   output logic             line_tx_o,
   input  wire logic        line_rx_i,
   output logic             resp_tx_o,
   input  wire logic        resp_rx_i
);

   typedef struct packed {
      logic [DIV_W-1:0] div;
      sbc_tx_state_t    tx_st;
      logic [11:0]      tx_sh;
      logic [3:0]       tx_cnt;
      logic [11:0]      tx_crc;
      logic             tx_test;
      logic             tx_busy;
      logic             line_tx;
      logic             sync_nak;
      logic [2:0]       rsp_in;
      logic [2:0]       rsp_out;
      logic [1:0]       rsp_cnt;
      logic             resp_tx;
      sbc_rx_state_t    rx_st;
      logic [11:0]      rx_sh;
      logic [3:0]       rx_cnt;
      logic [11:0]      rx_held;
      logic             held_v;
      logic [11:0]      rx_crc;
      logic [11:0]      rx_data;
      logic             rx_valid;
      logic             cyc_err;
      logic             err_sum;
      logic             rintr;
   } sbc_top_state_t;
   sbc_top_state_t s_ff;
   sbc_top_state_t nxt_s;
   logic           bit_en;
   logic           tx_go;
   logic           rsp_hit;
   logic           rx_word_end;
   logic [11:0]    rx_shift;
   logic [11:0]    fifo_data;
   logic           fifo_valid;
   logic           fifo_pop;
   logic           set_err;
   logic           set_intr;
   assign bit_en      = (s_ff.div == DIV_W'(BIT_CYCLES_P - 1));
   assign tx_go       = (s_ff.tx_st == TX_IDLE) && (tx_start_i || test_start_i);
   assign rx_shift    = {s_ff.rx_sh[10:0], line_rx_i};
   assign rsp_hit     = bit_en && ({s_ff.rsp_in[1:0], resp_rx_i} == RESP_CODE);
   assign rx_word_end = bit_en && (s_ff.rx_st == RX_BLOCK) && (s_ff.rx_cnt == LAST_BIT);
   // The buffer lets the host run a word or more ahead of the serial line.
   sbc_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_data_i   (tx_data_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      nxt_s      = s_ff;
      fifo_pop   = 1'b0;
      set_err    = 1'b0;
      set_intr   = 1'b0;
      nxt_s.div  = bit_en ? '0 : DIV_W'(s_ff.div + 1'b1);
      nxt_s.rx_valid = 1'b0;
      if (rsp_hit) begin
         nxt_s.sync_nak = 1'b0;
         nxt_s.rsp_in   = '0;
      end else if (bit_en) begin
         nxt_s.rsp_in = {s_ff.rsp_in[1:0], resp_rx_i};
      end
      if (tx_go) begin
         nxt_s.tx_st    = TX_SYNC;
         nxt_s.tx_sh    = SYNC_WORD;
         nxt_s.tx_cnt   = '0;
         nxt_s.tx_crc   = CRC_INIT_P;
         nxt_s.tx_test  = test_start_i;
         nxt_s.sync_nak = 1'b1;
      end else if (bit_en && s_ff.tx_st != TX_IDLE) begin
         nxt_s.line_tx = s_ff.tx_sh[11];
         nxt_s.tx_sh   = {s_ff.tx_sh[10:0], 1'b1};
         nxt_s.tx_cnt  = (s_ff.tx_cnt == LAST_BIT) ? 4'h0 : s_ff.tx_cnt + 4'h1;
         if (s_ff.tx_cnt == LAST_BIT) begin
            case (s_ff.tx_st)
               TX_SYNC, TX_DATA: begin
                  if (s_ff.tx_test && s_ff.tx_st == TX_SYNC) begin
                     nxt_s.tx_st  = TX_DATA;
                     nxt_s.tx_sh  = TEST_WORD;
                     nxt_s.tx_crc = sbc_crc_word(s_ff.tx_crc, TEST_WORD, CRC_POLY_P);
                  end else if (!s_ff.tx_test && fifo_valid) begin
                     fifo_pop     = 1'b1;
                     nxt_s.tx_st  = TX_DATA;
                     nxt_s.tx_sh  = fifo_data;
                     nxt_s.tx_crc = sbc_crc_word(s_ff.tx_crc, fifo_data, CRC_POLY_P);
                  end else begin
                     nxt_s.tx_st = TX_CHECK;
                     nxt_s.tx_sh = s_ff.tx_crc;
                  end
               end
               TX_CHECK: begin
                  // The idle word closes the block so the far receiver can check it.
                  nxt_s.tx_st = TX_GAP;
                  nxt_s.tx_sh = IDLE_WORD;
               end
               default: begin
                  nxt_s.tx_st = TX_IDLE;
               end
            endcase
         end
      end
      nxt_s.tx_busy = (nxt_s.tx_st != TX_IDLE);
      if (bit_en) begin
         if (s_ff.rsp_cnt != '0) begin
            nxt_s.resp_tx = s_ff.rsp_out[2];
            nxt_s.rsp_out = {s_ff.rsp_out[1:0], 1'b0};
            nxt_s.rsp_cnt = s_ff.rsp_cnt - 2'h1;
         end else begin
            nxt_s.resp_tx = 1'b0;
         end
         nxt_s.rx_sh = rx_shift;
         case (s_ff.rx_st)
            RX_HUNT: begin
               if (rx_enable_i && rx_shift == SYNC_WORD) begin
                  nxt_s.rx_st   = RX_BLOCK;
                  nxt_s.rx_cnt  = '0;
                  nxt_s.held_v  = 1'b0;
                  nxt_s.rx_crc  = CRC_INIT_P;
                  nxt_s.rsp_out = RESP_CODE;
                  nxt_s.rsp_cnt = RESP_BITS;
               end else if (rx_shift == INTR_WORD) begin
                  set_intr = 1'b1;
               end
            end
            RX_BLOCK: begin
               nxt_s.rx_cnt = (s_ff.rx_cnt == LAST_BIT) ? 4'h0 : s_ff.rx_cnt + 4'h1;
               if (!rx_enable_i) begin
                  nxt_s.rx_st = RX_HUNT;
               end else if (s_ff.rx_cnt == LAST_BIT) begin
                  if (rx_shift == IDLE_WORD) begin
                     // A data word equal to the idle pattern ends the block early.
                     nxt_s.rx_st = RX_HUNT;
                     set_err     = !s_ff.held_v || (s_ff.rx_held != s_ff.rx_crc);
                  end else begin
                     if (s_ff.held_v) begin
                        nxt_s.rx_crc   = sbc_crc_word(s_ff.rx_crc, s_ff.rx_held, CRC_POLY_P);
                        nxt_s.rx_data  = s_ff.rx_held;
                        nxt_s.rx_valid = 1'b1;
                     end
                     nxt_s.rx_held = rx_shift;
                     nxt_s.held_v  = 1'b1;
                  end
               end
            end
            default: begin
               nxt_s.rx_st = RX_HUNT;
            end
         endcase
      end
      // A new event wins over a clear in the same cycle.
      nxt_s.cyc_err = set_err | (s_ff.cyc_err & ~err_clr_i);
      nxt_s.err_sum = set_err | (s_ff.err_sum & ~err_clr_i);
      nxt_s.rintr   = set_intr | (s_ff.rintr & ~intr_clr_i);
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s_ff         <= '0;
         s_ff.line_tx <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end
   assign line_tx_o     = s_ff.line_tx;
   assign resp_tx_o     = s_ff.resp_tx;
   assign rx_data_o     = s_ff.rx_data;
   assign rx_valid_o    = s_ff.rx_valid;
   assign tx_busy_o     = s_ff.tx_busy;
   assign sync_nak_o    = s_ff.sync_nak;
   assign cyc_err_o     = s_ff.cyc_err;
   assign err_sum_o     = s_ff.err_sum;
   assign remote_intr_o = s_ff.rintr;

   // ************************************************************
   // Checks.
   // ************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   line_pace_a : assert property (!bit_en |=> $stable(line_tx_o))
      else $error("Line bit changed off the bit pace.");
   sync_start_a : assert property (tx_go |=> s_ff.tx_st == TX_SYNC && s_ff.tx_sh == SYNC_WORD && sync_nak_o)
      else $error("Block did not start with a sync word.");
   resp_clear_a : assert property (rsp_hit && !tx_go |=> !sync_nak_o)
      else $error("Response did not clear the unacknowledged flag.");
   check_after_a : assert property (bit_en && s_ff.tx_st == TX_DATA && s_ff.tx_cnt == LAST_BIT
      && !s_ff.tx_test && !fifo_valid |=> s_ff.tx_st == TX_CHECK && s_ff.tx_sh == $past(s_ff.tx_crc))
      else $error("Check word did not follow the last data word.");
   test_block_a : assert property (bit_en && s_ff.tx_test && s_ff.tx_st == TX_SYNC && s_ff.tx_cnt == LAST_BIT
      |=> s_ff.tx_sh == TEST_WORD ##0 s_ff.tx_st == TX_DATA)
      else $error("Test block did not carry the test word.");
   cyc_err_a : assert property (rx_word_end && rx_enable_i && rx_shift == IDLE_WORD && s_ff.held_v
      && s_ff.rx_held != s_ff.rx_crc |=> cyc_err_o && err_sum_o)
      else $error("Check mismatch did not raise the error flags.");
   err_sum_a : assert property (cyc_err_o |-> err_sum_o)
      else $error("Cyclic error without summary error.");
   sync_resp_a : assert property (bit_en && s_ff.rx_st == RX_HUNT && rx_enable_i && rx_shift == SYNC_WORD
      |=> s_ff.rsp_cnt == RESP_BITS && s_ff.rx_st == RX_BLOCK && s_ff.rx_crc == CRC_INIT_P)
      else $error("Sync word did not start the response.");
   resp_during_a : assert property (s_ff.rsp_cnt != '0 && s_ff.rx_st == RX_BLOCK && rx_enable_i
      |=> s_ff.rx_st == RX_BLOCK)
      else $error("Response sending disturbed reception.");
   intr_set_a : assert property (bit_en && s_ff.rx_st == RX_HUNT && rx_shift == INTR_WORD
      && !(rx_enable_i && rx_shift == SYNC_WORD) |=> remote_intr_o)
      else $error("Interrupt word did not raise the attention flag.");

   block_done_c : cover property (s_ff.tx_st == TX_GAP ##1 s_ff.tx_st == TX_IDLE);
   err_seen_c   : cover property ($rose(cyc_err_o));
   ack_seen_c   : cover property ($fell(sync_nak_o));
   intr_seen_c  : cover property ($rose(remote_intr_o));
endmodule // sbc_line_controller

// file: sbc_line_controller_tb.sv
`timescale 1ns/1ns

module sbc_line_controller_tb
   import sbc_pkg::*;
();
   localparam int BITC = 8;
   localparam int WT   = 12 * BITC;
   logic        core_clk_i = 1'b0;
   logic        sys_rst_i, tx_valid_i, tx_start_i, test_start_i, rx_enable_i, err_clr_i, intr_clr_i;
   logic [11:0] tx_data_i, rx_data_o;
   logic        tx_ready_o, rx_valid_o, tx_busy_o, sync_nak_o, cyc_err_o, err_sum_o, remote_intr_o;
   logic        line_tx_o, line_rx_i, resp_tx_o, resp_rx_i;
   int          error_cnt, checks_done;
   logic [11:0] got_q[$], exp_q[$], dq[$];
   logic [11:0] msk[3] = '{12'h001, 12'hFFF, 12'h810};
   int          pos[3] = '{1, 0, 3};

   always #2 core_clk_i = ~core_clk_i;

   sbc_line_controller #(.BIT_CYCLES_P(BITC)) dut_u (
      .core_clk_i, .sys_rst_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .tx_start_i, .test_start_i,
      .rx_enable_i, .rx_data_o, .rx_valid_o, .tx_busy_o, .sync_nak_o, .cyc_err_o, .err_sum_o,
      .remote_intr_o, .err_clr_i, .intr_clr_i, .line_tx_o, .line_rx_i, .resp_tx_o, .resp_rx_i
   );

   sbc_remote_model #(.BITC(BITC)) far_u (
      .core_clk_i, .sys_rst_i, .line_i(line_tx_o), .line_o(line_rx_i), .resp_i(resp_tx_o), .resp_o(resp_rx_i)
   );

   always @(posedge core_clk_i) begin
      if (rx_valid_o === 1'b1) got_q.push_back(rx_data_o);
   end

   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic run_block(input logic use_test, input int words);
      int n;
      n = 0;
      {test_start_i, tx_start_i} = {use_test, !use_test};
      @(negedge core_clk_i);
      {test_start_i, tx_start_i} = 2'h0;
      check({tx_busy_o, sync_nak_o}, 2'h3, "block started");
      while (tx_busy_o === 1'b1 && n < 20 * WT) begin
         @(negedge core_clk_i);
         n++;
      end
      // Busy drops as the last idle bit goes out, so up to one bit time short of whole words.
      check(n > words * WT - BITC && n <= words * WT, 1'b1, "block length");
      if (n >= 20 * WT) end_of_test();
      // The far end samples mid-bit, so let it take the last idle bit before its counters are read.
      repeat (BITC) @(negedge core_clk_i);
   endtask

   initial begin
      #80000;
      error_cnt++;
      $display("mismatch at %0t: run did not finish", $time);
      end_of_test();
   end

   initial begin
      {tx_valid_i, tx_start_i, test_start_i, rx_enable_i, err_clr_i, intr_clr_i} = 6'h00;
      tx_data_i = 12'h000;
      sys_rst_i = 1'b1;
      error_cnt = 0;
      checks_done = 0;
      repeat (16) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      check(line_tx_o, 1'b1, "idle line");
      check({tx_busy_o, sync_nak_o, cyc_err_o, err_sum_o, remote_intr_o}, 5'h00, "reset flags");
      // Offer one word more than the buffer holds; the last must be refused.
      for (int i = 0; i <= FIFO_DEPTH; i++) begin
         check(tx_ready_o, i < FIFO_DEPTH, "buffer ready");
         tx_data_i = 12'h120 + 12'(i);
         tx_valid_i = 1'b1;
         if (i < FIFO_DEPTH) exp_q.push_back(12'h120 + 12'(i));
         @(negedge core_clk_i);
      end
      tx_valid_i = 1'b0;
      run_block(1'b0, 11);
      check(12'(far_u.chk_ok_cnt), 12'h001, "far check word");
      check(12'(far_u.rx_q.size()), 12'h008, "far word count");
      foreach (exp_q[k]) check(far_u.rx_q[k], exp_q[k], "far data");
      check(sync_nak_o, 1'b0, "sync acknowledged");
      // Test block with the far end holding back its response.
      far_u.resp_en = 1'b0;
      run_block(1'b1, 4);
      check(far_u.rx_q[8], TEST_WORD, "test word");
      check(12'(far_u.chk_ok_cnt), 12'h002, "test check word");
      check(sync_nak_o, 1'b1, "no acknowledge");
      far_u.resp_en = 1'b1;
      rx_enable_i = 1'b1;
      dq = {12'h111, 12'h222, 12'h333};
      far_u.send_block(dq, 12'h000, 0);
      repeat (2 * BITC) @(negedge core_clk_i);
      check(12'(got_q.size()), 12'h003, "rx count");
      foreach (dq[k]) check(got_q[k], dq[k], "rx data");
      check({cyc_err_o, err_sum_o, remote_intr_o}, 3'h0, "clean block");
      check(12'(far_u.ack_cnt), 12'h001, "response seen");
      // Odd error, 12-bit burst in data, even burst on the check word.
      for (int t = 0; t < 3; t++) begin
         far_u.send_block(dq, msk[t], pos[t]);
         repeat (2 * BITC) @(negedge core_clk_i);
         check({cyc_err_o, err_sum_o}, 2'h3, "block error");
         err_clr_i = 1'b1;
         @(negedge core_clk_i);
         err_clr_i = 1'b0;
         @(negedge core_clk_i);
         check({cyc_err_o, err_sum_o}, 2'h0, "error cleared");
      end
      far_u.send_word(INTR_WORD);
      far_u.send_word(IDLE_WORD);
      check(remote_intr_o, 1'b1, "remote attention");
      intr_clr_i = 1'b1;
      @(negedge core_clk_i);
      intr_clr_i = 1'b0;
      @(negedge core_clk_i);
      check(remote_intr_o, 1'b0, "attention cleared");
      end_of_test();
   end
endmodule // sbc_line_controller_tb

// file: sbc_pkg.sv
// ************************************************************
// Word format, timing and check code constants.
// ************************************************************
package sbc_pkg;

   localparam int WORD_W        = 12;
   localparam int RESP_W        = 3;
   localparam int CLK_PERIOD_NS = 4;
   localparam int WORD_TIME_US  = 300;
   localparam int BIT_TIME_NS   = (WORD_TIME_US * 1000) / WORD_W;
   localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
   localparam int DIV_W         = 13;
   localparam int FIFO_DEPTH    = 8;

   localparam logic [3:0]  LAST_BIT   = 4'hB;
   localparam logic [1:0]  RESP_BITS  = 2'h3;
   localparam logic [2:0]  RESP_CODE  = 3'h5;
   // The polynomial holds the factor x+1, so any odd count of bit errors shows.
   localparam logic [11:0] CRC_POLY   = 12'h80F;
   localparam logic [11:0] CRC_INIT   = 12'h000;
   localparam logic [11:0] SYNC_WORD  = 12'h5A3;
   localparam logic [11:0] IDLE_WORD  = 12'hFFF;
   localparam logic [11:0] INTR_WORD  = 12'h3C6;
   localparam logic [11:0] TEST_WORD  = 12'hA5C;

   typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_DATA, TX_CHECK, TX_GAP} sbc_tx_state_t;
   typedef enum logic [0:0] {RX_HUNT, RX_BLOCK} sbc_rx_state_t;

   // ************************************************************
   // Serial cyclic code over one word, most significant bit first.
   // ************************************************************
   function automatic logic [11:0] sbc_crc_word(input logic [11:0] crc_in,
                                                input logic [11:0] data,
                                                input logic [11:0] poly);
      logic [11:0] c;
      logic        fb;
      c = crc_in;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         fb = c[11] ^ data[i];
         c  = {c[10:0], 1'b0};
         if (fb) begin
            c = c ^ poly;
         end
      end
      return c;
   endfunction

endpackage

// file: sbc_remote_model.sv
`timescale 1ns/1ns

// ************************************************************
// Far-end controller model: block sender, checker, responder.
// ************************************************************
module sbc_remote_model
   import sbc_pkg::*;
#(
   parameter int BITC = 8
) (
   // Clock and reset.
   input  wire logic core_clk_i,
   input  wire logic sys_rst_i,
   // Line pair toward the near controller.
   input  wire logic line_i,
   output logic      line_o,
   input  wire logic resp_i,
   output logic      resp_o
);
   int          ph, bits, resp_left, blk_cnt, chk_ok_cnt, ack_cnt;
   logic [11:0] sh, held, crc;
   logic [2:0]  rh;
   bit          in_blk, have_held;
   bit          resp_en = 1'b1;
   logic [11:0] rx_q[$];

   function automatic logic [11:0] crc12(input logic [11:0] c, input logic [11:0] d);
      for (int i = 11; i >= 0; i--) begin
         c = (c[11] ^ d[i]) ? ({c[10:0], 1'b0} ^ CRC_POLY) : {c[10:0], 1'b0};
      end
      return c;
   endfunction

   initial begin
      line_o = 1'b1;
      resp_o = 1'b0;
   end

   // Sampling sits mid-bit, so either end may lead by a clock without harm.
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ph = 0;
         in_blk = 1'b0;
         resp_left = 0;
         sh = IDLE_WORD;
         rh = 3'h0;
         resp_o <= 1'b0;
      end else begin
         ph = (ph == BITC - 1) ? 0 : ph + 1;
         if (ph == 3) begin
            rh = {rh[1:0], resp_i};
            if (rh == RESP_CODE) ack_cnt++;
            resp_o <= (resp_left > 0) ? RESP_CODE[resp_left - 1] : 1'b0;
            if (resp_left > 0) resp_left--;
            sh = {sh[10:0], line_i};
            bits++;
            if (!in_blk && sh == SYNC_WORD) begin
               in_blk = 1'b1;
               bits = 0;
               have_held = 1'b0;
               crc = CRC_INIT;
               if (resp_en) resp_left = 3;
            end else if (in_blk && bits == 12) begin
               bits = 0;
               if (sh == IDLE_WORD) begin
                  in_blk = 1'b0;
                  blk_cnt++;
                  if (have_held && held == crc) chk_ok_cnt++;
               end else begin
                  if (have_held) begin
                     rx_q.push_back(held);
                     crc = crc12(crc, held);
                  end
                  held = sh;
                  have_held = 1'b1;
               end
            end
         end
      end
   end

   task automatic send_word(input logic [11:0] w);
      int k;
      for (int i = 11; i >= 0; i--) begin
         k = 0;
         do begin
            @(negedge core_clk_i);
            k++;
         end while (ph != 3 && k < 2 * BITC);
         if (ph != 3) begin
            sbc_line_controller_tb.error_cnt++;
            $display("mismatch at %0t: far bit pace lost", $time);
         end
         line_o = w[i];
      end
   endtask

   // A flip at index d.size() lands on the check word itself.
   task automatic send_block(input logic [11:0] d[$], input logic [11:0] flip, input int at);
      logic [11:0] c;
      c = CRC_INIT;
      send_word(SYNC_WORD);
      foreach (d[k]) begin
         c = crc12(c, d[k]);
         send_word(k == at ? d[k] ^ flip : d[k]);
      end
      send_word(at == d.size() ? c ^ flip : c);
      send_word(IDLE_WORD);
   endtask
endmodule // sbc_remote_model
